// File: dv/host_model.sv
// Host processor model for the register port of the power and queue bank.
// Assumes the bench calls access(); drives on falling edges.
`timescale 1ns/1ps
module host_model (
    input wire logic i_sys_clk,
    input wire logic i_ack,
    output power_fifo_pkg::reg_req_t o_req
);
    // The port is idle until the first access.
    initial o_req = '0;
    // One access: a one-cycle request, then a bounded wait for the ack.
    task automatic access(input logic rd, input logic [6:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge i_sys_clk);
        o_req = {rd, ~rd, a, d};
        @(negedge i_sys_clk);
        o_req = '0;
        while (i_ack !== 1'b1 && n < 8)
        begin
            @(negedge i_sys_clk);
            n++;
        end
    endtask
endmodule

// File: dv/tb_top.sv
// Self-checking bench of the power control and sample queue bank.
// Assumes the host model of host_model.sv and a 50 MHz clock.
`timescale 1ns/1ps
module tb_top;
    logic i_sys_clk = 1'b0;
    logic i_reset = 1'b1;
    logic q_en = 1'b1;
    logic tick = 1'b0;
    logic clr = 1'b0;
    logic otp = 1'b0;
    logic doze = 1'b0;
    logic pol = 1'b0;
    logic wake;
    logic smp;
    int wakes = 0;
    int samples = 0;
    logic [7:0] flags = 8'h00;
    logic [power_fifo_pkg::SENSOR_BYTES-1:0][7:0] sens;
    logic [7:0] rdata;
    logic ack;
    logic ovf;
    power_fifo_pkg::power_status_t stat;
    power_fifo_pkg::reg_req_t req;
    int failures = 0;
    int total_checks = 0;
    int cyc = 0;
    host_model i_host_model (.i_sys_clk(i_sys_clk), .i_ack(ack), .o_req(req));
    power_fifo_access_regs #(.IDENTITY_VALUE(8'h3c), .WAKE_BASE_COUNT(4)) i_power_fifo_access_regs (
        .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_reg_req(req), .o_reg_rdata(rdata),
        .o_reg_ack(ack), .i_otp_load_done(otp), .i_powerup_doze_default(doze),
        .i_pll_ready(1'b1), .i_accel_wake_rate(4'h0), .i_queue_enable(q_en),
        .i_queue_full_policy(pol), .i_queue_source_flags(flags), .i_ext_byte_enable('0),
        .i_sample_tick(tick), .i_sensor_bytes(sens), .i_overrun_clear(clr),
        .o_queue_overrun_flag(ovf), .o_wake_pulse(wake), .o_accel_sample_pulse(smp),
        .o_status(stat));
    // ------------------------------------------------------------------
    // Clock, hang limit and helper tasks
    // ------------------------------------------------------------------
    initial forever #10 i_sys_clk = ~i_sys_clk;
    // Cuts a hung run short well past the expected length.
    always @(posedge i_sys_clk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            failures++;
            end_sim();
        end
    end
    // Counts wake and sample pulses; each stands a full cycle, so one look per cycle.
    always @(negedge i_sys_clk)
    begin
        wakes += int'(wake);
        samples += int'(smp);
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        i_host_model.access(1'b1, a, 8'h00);
        check(rdata, e);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        i_host_model.access(1'b0, a, d);
    endtask
    task automatic end_sim;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Main sequence: registers, soft reset, OTP load, host queue use, a sample scan, keep policy, then cycled wake-up.
    initial
    begin
        for (int k = 0; k < power_fifo_pkg::SENSOR_BYTES; k++)
            sens[k] = 8'h40 + 8'(k);
        repeat (4) @(negedge i_sys_clk);
        i_reset = 1'b0;
        wr(7'h75, 8'hff);
        rd(7'h75, 8'h3c);
        wr(7'h6c, 8'h38);
        check({5'h00, stat.accel_on}, 8'h00);
        rd(7'h6c, 8'h38);
        wr(7'h6b, 8'h08);
        check({7'h00, stat.temp_ref_on}, 8'h00);
        wr(7'h6b, 8'h80);
        rd(7'h6b, 8'h00);
        rd(7'h6c, 8'h00);
        otp = 1'b1;
        doze = 1'b1;
        @(negedge i_sys_clk);
        otp = 1'b0;
        rd(7'h6b, 8'h40);
        check({7'h00, stat.sleep}, 8'h01);
        doze = 1'b0;
        otp = 1'b1;
        @(negedge i_sys_clk);
        otp = 1'b0;
        rd(7'h6b, 8'h01);
        check({7'h00, stat.use_pll}, 8'h01);
        q_en = 1'b0;
        wr(7'h74, 8'h77);
        q_en = 1'b1;
        for (int i = 0; i < 9; i++)
            wr(7'h74, 8'h10 + 8'(i));
        check({7'h00, ovf}, 8'h01);
        wr(7'h72, 8'h55);
        rd(7'h72, 8'h00);
        rd(7'h73, 8'h08);
        for (int i = 0; i < 8; i++)
            rd(7'h74, 8'h11 + 8'(i));
        rd(7'h74, 8'h18);
        clr = 1'b1;
        flags = 8'h08;
        tick = 1'b1;
        @(negedge i_sys_clk);
        clr = 1'b0;
        tick = 1'b0;
        repeat (45) @(negedge i_sys_clk);
        check({7'h00, ovf}, 8'h00);
        rd(7'h72, 8'h00);
        rd(7'h74, 8'h40);
        rd(7'h73, 8'h06);
        for (int i = 1; i < 6; i++)
            rd(7'h74, 8'h40 + 8'(i));
        pol = 1'b1;
        for (int i = 0; i < 9; i++)
            wr(7'h74, 8'h20 + 8'(i));
        check({7'h00, ovf}, 8'h01);
        for (int i = 0; i < 8; i++)
            rd(7'h74, 8'h20 + 8'(i));
        wr(7'h6b, 8'h28);
        repeat (16) @(negedge i_sys_clk);
        check(8'(wakes), 8'h04);
        check(8'(samples), 8'h04);
        wr(7'h6c, 8'h3f);
        check({7'h00, stat.low_power}, 8'h01);
        repeat (16) @(negedge i_sys_clk);
        check(8'(wakes), 8'h08);
        check(8'(samples), 8'h04);
        wr(7'h6b, 8'h07);
        check({7'h00, stat.clock_halt}, 8'h01);
        end_sim();
    end
endmodule

// File: pkg/power_fifo_pkg.sv
// Shared constants and types of the power control and sample queue register bank.
// Assumes a byte-wide register port with 7-bit addresses and one clock of 50 MHz.
package power_fifo_pkg;

    // ------------------------------------------------------------------
    // Register addresses and field positions
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_POWER_PRIMARY = 7'h6b;
    localparam logic [6:0] ADDR_AXIS_POWER = 7'h6c;
    localparam logic [6:0] ADDR_COUNT_HIGH = 7'h72;
    localparam logic [6:0] ADDR_COUNT_LOW = 7'h73;
    localparam logic [6:0] ADDR_DATA_PORT = 7'h74;
    localparam logic [6:0] ADDR_IDENTITY = 7'h75;
    localparam int SOFT_RESET_BIT = 7;
    localparam int SLEEP_BIT = 6;
    localparam int CYCLE_BIT = 5;
    localparam int STANDBY_BIT = 4;
    localparam int TEMP_PD_BIT = 3;
    localparam logic [2:0] CLOCK_SOURCE_SELECT_OSC = 3'h0;
    localparam logic [2:0] CLOCK_SOURCE_SELECT_OSC_ALT = 3'h6;
    localparam logic [2:0] CLOCK_SOURCE_SELECT_STOP = 3'h7;
    localparam logic [7:0] POWER_PRIMARY_RESET = 8'h00;
    localparam logic [7:0] AXIS_POWER_RESET = 8'h00;
    localparam logic [7:0] AXIS_POWER_MASK = 8'h3f;

    // ------------------------------------------------------------------
    // Queue and sensor byte layout
    // ------------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int QUEUE_DEPTH = 8;
    localparam int COUNT_W = 13;
    localparam int FIRST_SENSOR_REG = 59;
    localparam int LAST_SENSOR_REG = 96;
    localparam int SENSOR_BYTES = LAST_SENSOR_REG - FIRST_SENSOR_REG + 1;
    localparam int ACCEL_FIRST = 0;
    localparam int TEMP_FIRST = 6;
    localparam int RATE_FIRST = 8;
    localparam int EXT_FIRST = 14;
    localparam int EXT_BYTES = SENSOR_BYTES - EXT_FIRST;
    localparam int FLAG_TEMP = 7;
    localparam int FLAG_RATE_X = 6;
    localparam int FLAG_ACCEL = 3;

    // ------------------------------------------------------------------
    // Timing of the cycled wake-up
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int WAKE_BASE_US = 1000;
    localparam int WAKE_BASE_CYCLES = WAKE_BASE_US * CLK_MHZ;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [6:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic sleep;
        logic cycle_active;
        logic low_power;
        logic clock_halt;
        logic use_pll;
        logic rate_drive_on;
        logic [2:0] rate_sense_on;
        logic temp_ref_on;
        logic [2:0] accel_on;
    } power_status_t;

    typedef enum logic [0:0] {SEQ_IDLE, SEQ_SCAN} seq_state_t;

endpackage

// File: rtl/power_fifo_access_regs.sv
// Power control register bank with the sample queue access port and identity register.
// Assumes host requests arrive synchronous to i_sys_clk, one at most per cycle.
//
// Contract
// RULE1: Writing one to bit 7 of power primary restores all defaults; bit self-clears.
// RULE2: Sleep bit puts device asleep; after OTP load it takes doze default.
// RULE3: Cycle bit with sleep and standby clear alternates sleep and single samples.
// RULE4: Cycling with all accel axes off still wakes but takes no sample.
// RULE5: Rate standby keeps gyro drive and PLL on, sense paths off.
// RULE6: Temp reference power-down switches off the temperature generator and converter.
// RULE7: Clock codes 0,6 oscillator; 1-5 PLL when ready; 7 stops timing.
// RULE8: After OTP load, clock select bit 0 takes inverse of doze default.
// RULE9: Axis power bits 5..3 disable accel X,Y,Z; bits 2..0 gyro X,Y,Z.
// RULE10: Host enters accel-only mode: cycle, clear sleep, temp off, gyros off.
// RULE11: Accel-only mode powers all off except serial port, waking accel periodically.
// RULE12: Byte count is 13 bits: high register bits 4:0, low register bits 7:0.
// RULE13: Reading count high latches both bytes; host reads high before low.
// RULE14: Data port read pops one byte; data port write pushes one byte.
// RULE15: Each sample tick pushes enabled sensor bytes 59..96 in ascending order.
// RULE16: A sensor byte is pushed only when its enable flag is set.
// RULE17: Queue overflow sets the overrun flag.
// RULE18: Overflow drops oldest byte unless full policy set, then drops new byte.
// RULE19: Empty data port read returns the last byte read.
// RULE20: Host checks byte count before reading the data port.
// RULE21: Read-only 8-bit identity register at address 117.
// RULE22: Queue enable allows queue operation; clear blocks serial queue access.
// RULE23: Writes to count and identity registers are ignored.
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Byte queue
// ----------------------------------------------------------------------
module byte_queue #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_flush,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data,
    output logic [$clog2(DEPTH+1)-1:0] o_count
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [CNT_W-1:0] count;
    } queue_state_t;

    queue_state_t q_reg;
    queue_state_t q_next;
    logic do_push;
    logic do_pop;

    // A full queue still takes a byte when one leaves in the same cycle.
    assign o_out_valid = (q_reg.count != '0);
    assign o_in_ready = (q_reg.count != FULL_COUNT) || i_out_ready;
    assign o_out_data = q_reg.mem[q_reg.rd_ptr];
    assign o_count = q_reg.count;
    assign do_push = i_in_valid && o_in_ready;
    assign do_pop = i_out_ready && o_out_valid;

    // Pointer and count update.
    always_comb
    begin
        q_next = q_reg;
        if (do_push)
        begin
            q_next.mem[q_reg.wr_ptr] = i_in_data;
            q_next.wr_ptr = (q_reg.wr_ptr == LAST_PTR) ? '0 : q_reg.wr_ptr + 1'b1;
        end
        if (do_pop)
        begin
            q_next.rd_ptr = (q_reg.rd_ptr == LAST_PTR) ? '0 : q_reg.rd_ptr + 1'b1;
        end
        if (do_push && !do_pop)
        begin
            q_next.count = q_reg.count + 1'b1;
        end
        else if (do_pop && !do_push)
        begin
            q_next.count = q_reg.count - 1'b1;
        end
        if (i_flush)
        begin
            q_next.wr_ptr = '0;
            q_next.rd_ptr = '0;
            q_next.count = '0;
        end
    end

    // State register.
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            q_reg <= '0;
        end
        else
        begin
            q_reg <= q_next;
        end
    end
endmodule

// ----------------------------------------------------------------------
// Register bank
// ----------------------------------------------------------------------
module power_fifo_access_regs #(
    parameter logic [7:0] IDENTITY_VALUE = 8'h5a, // Arbitrary value.
    parameter int WAKE_BASE_COUNT = power_fifo_pkg::WAKE_BASE_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire power_fifo_pkg::reg_req_t i_reg_req,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_ack,
    input wire logic i_otp_load_done,
    input wire logic i_powerup_doze_default,
    input wire logic i_pll_ready,
    input wire logic [3:0] i_accel_wake_rate,
    input wire logic i_queue_enable,
    input wire logic i_queue_full_policy,
    input wire logic [7:0] i_queue_source_flags,
    input wire logic [power_fifo_pkg::EXT_BYTES-1:0] i_ext_byte_enable,
    input wire logic i_sample_tick,
    input wire logic [power_fifo_pkg::SENSOR_BYTES-1:0][7:0] i_sensor_bytes,
    input wire logic i_overrun_clear,
    output logic o_queue_overrun_flag,
    output logic o_wake_pulse,
    output logic o_accel_sample_pulse,
    output power_fifo_pkg::power_status_t o_status
);
    localparam int CNT_W = $clog2(power_fifo_pkg::QUEUE_DEPTH + 1);
    localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(power_fifo_pkg::QUEUE_DEPTH);
    localparam logic [5:0] LAST_IDX = 6'(power_fifo_pkg::SENSOR_BYTES - 1);
    localparam logic [15:0] BASE_LAST = 16'(WAKE_BASE_COUNT - 1);

    typedef struct packed {
        logic [7:0] power_primary;
        logic [7:0] axis_power;
        logic [power_fifo_pkg::COUNT_W-1:0] count_latch;
        logic [7:0] last_read;
        logic [7:0] rdata;
        logic ack;
        logic overrun;
        power_fifo_pkg::seq_state_t seq;
        logic [5:0] idx;
        logic [15:0] base_cnt;
        logic [11:0] wake_cnt;
        logic wake;
        logic sample;
        power_fifo_pkg::power_status_t status;
    } bank_state_t;

    localparam bank_state_t RESET_STATE = '{
        power_primary: power_fifo_pkg::POWER_PRIMARY_RESET,
        axis_power: power_fifo_pkg::AXIS_POWER_RESET,
        seq: power_fifo_pkg::SEQ_IDLE,
        default: '0
    };

    bank_state_t s_reg;
    bank_state_t s_next;
    logic soft_reset;
    logic host_pop;
    logic host_push;
    logic seq_push;
    logic push_req;
    logic discard;
    logic overflow;
    logic queue_full;
    logic in_valid;
    logic in_ready;
    logic out_valid;
    logic [7:0] out_data;
    logic [7:0] push_data;
    logic [CNT_W-1:0] queue_count;
    logic [power_fifo_pkg::COUNT_W-1:0] live_count;
    logic byte_on;

    // Whether sensor byte idx is selected for the queue.
    function automatic logic byte_selected(input logic [5:0] idx, input logic [7:0] flags,
                                           input logic [power_fifo_pkg::EXT_BYTES-1:0] ext);
        int i;
        logic sel;
        i = int'(idx);
        sel = 1'b0;
        if (i < power_fifo_pkg::TEMP_FIRST)
            sel = flags[power_fifo_pkg::FLAG_ACCEL];
        else if (i < power_fifo_pkg::RATE_FIRST)
            sel = flags[power_fifo_pkg::FLAG_TEMP];
        else if (i < power_fifo_pkg::EXT_FIRST)
            sel = flags[power_fifo_pkg::FLAG_RATE_X - (i - power_fifo_pkg::RATE_FIRST) / 2];
        else if (i < power_fifo_pkg::SENSOR_BYTES)
            sel = ext[i - power_fifo_pkg::EXT_FIRST];
        return sel;
    endfunction

    byte_queue #(
        .WIDTH(power_fifo_pkg::DATA_W),
        .DEPTH(power_fifo_pkg::QUEUE_DEPTH)
    ) u_queue (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_flush(soft_reset),
        .i_in_valid(in_valid),
        .o_in_ready(in_ready),
        .i_in_data(push_data),
        .o_out_valid(out_valid),
        .i_out_ready(host_pop || discard),
        .o_out_data(out_data),
        .o_count(queue_count)
    );

    // Host access decode; queue traffic only while the queue is enabled.
    assign soft_reset = i_reg_req.wr && (i_reg_req.addr == power_fifo_pkg::ADDR_POWER_PRIMARY)
                        && i_reg_req.wdata[power_fifo_pkg::SOFT_RESET_BIT]; // RULE1
    assign host_pop = i_reg_req.rd && (i_reg_req.addr == power_fifo_pkg::ADDR_DATA_PORT)
                      && i_queue_enable && out_valid; // RULE14 RULE22
    assign host_push = i_reg_req.wr && (i_reg_req.addr == power_fifo_pkg::ADDR_DATA_PORT)
                       && i_queue_enable; // RULE14 RULE22
    assign byte_on = byte_selected(s_reg.idx, i_queue_source_flags, i_ext_byte_enable); // RULE16
    assign seq_push = (s_reg.seq == power_fifo_pkg::SEQ_SCAN) && byte_on && !host_push;
    assign push_req = host_push || seq_push;
    assign push_data = host_push ? i_reg_req.wdata : i_sensor_bytes[s_reg.idx];
    assign queue_full = (queue_count == FULL_COUNT);
    // When full, drop the oldest byte unless the policy keeps old data.
    assign discard = push_req && queue_full && !host_pop && !i_queue_full_policy; // RULE18
    assign overflow = push_req && queue_full && !host_pop; // RULE17
    assign in_valid = push_req && !soft_reset && (!queue_full || host_pop || discard);
    assign live_count = power_fifo_pkg::COUNT_W'(queue_count); // RULE12

    // Next-state logic of the whole bank, power status decode included.
    always_comb
    begin
        logic [7:0] p;
        logic [7:0] a;
        logic halt;
        s_next = s_reg;
        p = 8'h00;
        a = 8'h00;
        halt = 1'b0;
        s_next.ack = 1'b0;
        s_next.wake = 1'b0;
        s_next.sample = 1'b0;
        // Register reads.
        if (i_reg_req.rd)
        begin
            s_next.ack = 1'b1;
            case (i_reg_req.addr)
                power_fifo_pkg::ADDR_POWER_PRIMARY:
                    s_next.rdata = s_reg.power_primary;
                power_fifo_pkg::ADDR_AXIS_POWER:
                    s_next.rdata = s_reg.axis_power & power_fifo_pkg::AXIS_POWER_MASK;
                power_fifo_pkg::ADDR_COUNT_HIGH:
                begin
                    s_next.count_latch = live_count; // RULE13
                    s_next.rdata = {3'h0, live_count[12:8]}; // RULE12
                end
                power_fifo_pkg::ADDR_COUNT_LOW:
                    s_next.rdata = s_reg.count_latch[7:0]; // RULE13
                power_fifo_pkg::ADDR_DATA_PORT:
                begin
                    if (host_pop)
                    begin
                        s_next.rdata = out_data;
                        s_next.last_read = out_data;
                    end
                    else
                    begin
                        s_next.rdata = s_reg.last_read; // RULE19
                    end
                end
                power_fifo_pkg::ADDR_IDENTITY:
                    s_next.rdata = IDENTITY_VALUE; // RULE21
                default:
                    s_next.rdata = 8'h00;
            endcase
        end
        // Register writes; count and identity addresses take none.
        if (i_reg_req.wr)
        begin
            s_next.ack = 1'b1;
            case (i_reg_req.addr)
                power_fifo_pkg::ADDR_POWER_PRIMARY:
                    s_next.power_primary = {1'b0, i_reg_req.wdata[6:0]};
                power_fifo_pkg::ADDR_AXIS_POWER:
                    s_next.axis_power = i_reg_req.wdata & power_fifo_pkg::AXIS_POWER_MASK; // RULE9
                default:
                    s_next.power_primary = s_reg.power_primary; // RULE23
            endcase
        end
        // Power-up defaults delivered by the one-time-programmable load.
        if (i_otp_load_done)
        begin
            s_next.power_primary[power_fifo_pkg::SLEEP_BIT] = i_powerup_doze_default; // RULE2
            s_next.power_primary[0] = !i_powerup_doze_default; // RULE8
        end
        // Overrun flag: a new overflow wins over a clear in the same cycle.
        if (i_overrun_clear)
            s_next.overrun = 1'b0;
        if (overflow)
            s_next.overrun = 1'b1; // RULE17
        // Sequencer pushes the selected sensor bytes in ascending order.
        case (s_reg.seq)
            power_fifo_pkg::SEQ_IDLE:
            begin
                if (i_sample_tick && i_queue_enable)
                begin
                    s_next.seq = power_fifo_pkg::SEQ_SCAN; // RULE15
                    s_next.idx = 6'h00;
                end
            end
            power_fifo_pkg::SEQ_SCAN:
            begin
                if (!host_push && (!byte_on || in_ready || i_queue_full_policy))
                begin
                    s_next.idx = s_reg.idx + 6'h01; // RULE15
                    if (s_reg.idx == LAST_IDX)
                        s_next.seq = power_fifo_pkg::SEQ_IDLE;
                end
            end
            default:
                s_next.seq = power_fifo_pkg::SEQ_IDLE;
        endcase
        // Soft reset returns the whole bank to its defaults and still acknowledges.
        if (soft_reset)
        begin
            s_next = RESET_STATE; // RULE1
            s_next.ack = 1'b1;
        end
        // Power status decode from the next control values, so it follows each write.
        p = s_next.power_primary;
        a = s_next.axis_power;
        halt = (p[2:0] == power_fifo_pkg::CLOCK_SOURCE_SELECT_STOP); // RULE7
        s_next.status.sleep = p[power_fifo_pkg::SLEEP_BIT]; // RULE2
        s_next.status.clock_halt = halt;
        s_next.status.use_pll = !halt && (p[2:0] != power_fifo_pkg::CLOCK_SOURCE_SELECT_OSC)
                                && (p[2:0] != power_fifo_pkg::CLOCK_SOURCE_SELECT_OSC_ALT) && i_pll_ready;
        s_next.status.cycle_active = p[power_fifo_pkg::CYCLE_BIT] && !halt
                                     && !p[power_fifo_pkg::SLEEP_BIT]
                                     && !p[power_fifo_pkg::STANDBY_BIT]; // RULE3
        s_next.status.low_power = s_next.status.cycle_active && p[power_fifo_pkg::TEMP_PD_BIT]
                                  && (a[2:0] == 3'h7); // RULE11
        s_next.status.rate_drive_on = !p[power_fifo_pkg::SLEEP_BIT] && !halt
                                      && !s_next.status.low_power; // RULE5
        s_next.status.rate_sense_on = (!p[power_fifo_pkg::SLEEP_BIT] && !halt
                                      && !p[power_fifo_pkg::STANDBY_BIT]) ? ~a[2:0] : 3'h0; // RULE5
        s_next.status.temp_ref_on = !p[power_fifo_pkg::TEMP_PD_BIT]
                                    && !p[power_fifo_pkg::SLEEP_BIT] && !halt; // RULE6
        s_next.status.accel_on = (!p[power_fifo_pkg::SLEEP_BIT] && !halt
                                 && !s_next.status.cycle_active) ? ~a[5:3] : 3'h0; // RULE9
        // Cycled wake-up divider; the base tick divides further by two to the rate, and by 4096 for rates 12 to 15.
        // It runs after the decode, and a soft reset leaves cycling off, so it only clears.
        if (s_next.status.cycle_active)
        begin
            if (s_reg.base_cnt == BASE_LAST)
            begin
                s_next.base_cnt = 16'h0000;
                if (s_reg.wake_cnt == ((12'h001 << i_accel_wake_rate) - 12'h001))
                begin
                    s_next.wake_cnt = 12'h000;
                    s_next.wake = 1'b1; // RULE3
                    s_next.sample = (s_reg.axis_power[5:3] != 3'h7); // RULE4
                end
                else
                begin
                    s_next.wake_cnt = s_reg.wake_cnt + 12'h001;
                end
            end
            else
            begin
                s_next.base_cnt = s_reg.base_cnt + 16'h0001;
            end
        end
        else
        begin
            s_next.base_cnt = 16'h0000;
            s_next.wake_cnt = 12'h000;
        end
    end

    // State register.
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            s_reg <= RESET_STATE;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register.
    assign o_reg_rdata = s_reg.rdata;
    assign o_reg_ack = s_reg.ack;
    assign o_queue_overrun_flag = s_reg.overrun;
    assign o_wake_pulse = s_reg.wake;
    assign o_accel_sample_pulse = s_reg.sample;
    assign o_status = s_reg.status;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    sequence read_high_s;
        i_reg_req.rd && !i_reg_req.wr && (i_reg_req.addr == power_fifo_pkg::ADDR_COUNT_HIGH);
    endsequence

    sequence read_low_s;
        i_reg_req.rd && !i_reg_req.wr && (i_reg_req.addr == power_fifo_pkg::ADDR_COUNT_LOW);
    endsequence

    a_soft_reset_defaults: assert property (soft_reset |=> (s_reg.power_primary ==
        power_fifo_pkg::POWER_PRIMARY_RESET) && (queue_count == '0) && !o_queue_overrun_flag) // RULE1
        else $error("soft reset did not restore defaults");
    a_otp_load_values: assert property (i_otp_load_done && !soft_reset |=>
        (s_reg.power_primary[6] == $past(i_powerup_doze_default))
        && (s_reg.power_primary[0] == !$past(i_powerup_doze_default))) // RULE8
        else $error("otp load values wrong");
    a_clock_stop_halt: assert property (s_reg.power_primary[2:0] == power_fifo_pkg::CLOCK_SOURCE_SELECT_STOP
        |-> o_status.clock_halt && !o_status.use_pll && !o_wake_pulse) // RULE7
        else $error("clock code seven did not halt timing");
    a_count_pair_read: assert property (read_high_s ##[1:2] read_low_s |=>
        o_reg_rdata == $past(s_reg.count_latch[7:0])) // RULE13
        else $error("low count byte not from latch");
    a_count_high_value: assert property (read_high_s and !soft_reset |=>
        o_reg_ack && (o_reg_rdata == {3'h0, $past(live_count[12:8])})) // RULE12
        else $error("high count byte wrong");
    a_empty_read_last: assert property (i_reg_req.rd && !soft_reset
        && (i_reg_req.addr == power_fifo_pkg::ADDR_DATA_PORT) && !out_valid
        |=> o_reg_rdata == $past(s_reg.last_read)) // RULE19
        else $error("empty read did not return last byte");
    a_overrun_sets: assert property (overflow && !soft_reset |=> o_queue_overrun_flag) // RULE17
        else $error("overflow did not set flag");
    a_keep_old_data: assert property (push_req && queue_full && i_queue_full_policy && !host_pop
        && !soft_reset |-> !discard && !in_valid ##1 queue_count == FULL_COUNT) // RULE18
        else $error("old data overwritten under keep policy");
    a_identity_read: assert property (i_reg_req.rd && !soft_reset
        && (i_reg_req.addr == power_fifo_pkg::ADDR_IDENTITY) |=> o_reg_rdata == IDENTITY_VALUE) // RULE21
        else $error("identity read wrong");
    a_no_sample_off: assert property (s_reg.axis_power[5:3] == 3'h7 && $stable(s_reg.axis_power)
        |=> !o_accel_sample_pulse) // RULE4
        else $error("sample taken with all accel axes off");
endmodule
